// File: logic/pcd_pkg.sv
// shared types, constants and decode helpers for the configuration access decoder
package pcd_pkg;

    localparam int IO_ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int REG_NUM_W = 6;
    localparam int CFG_DEVS = 2;

    localparam logic [IO_ADDR_W-1:0] IO_PTR_ADDR = 16'h0CF8;
    localparam logic [IO_ADDR_W-1:0] IO_WIN_ADDR = 16'h0CFC;

    localparam logic [7:0] BUS_ZERO = 8'h00;
    localparam logic [4:0] DEV_HOST = 5'h00;
    localparam logic [4:0] DEV_GFX = 5'h01;
    localparam logic [2:0] FUNC_ZERO = 3'h0;
    localparam logic [LANES-1:0] BE_DWORD = 4'hF;

    localparam logic [DATA_W-1:0] PTR_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PTR_WRITE_MASK = 32'h80FF_FFFC;
    localparam logic [DATA_W-1:0] ABORT_DATA = 32'hFFFF_FFFF;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [7:0] HUB_ADDR_FILL = 8'h00;
    localparam logic [1:0] ADDR_LOW_ZERO = 2'h0;
    localparam logic [IO_ADDR_W-1:0] IO_ADDR_FILL = 16'h0000;

    // address pointer layout, bit 31 down to bit 0
    typedef struct packed {
        logic enable;
        logic [6:0] rsvd_hi;
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] func;
        logic [REG_NUM_W-1:0] regnum;
        logic [1:0] rsvd_lo;
    } pcd_ptr_t;

    typedef enum logic [1:0] {
        RT_HOST = 2'h0,
        RT_GFX = 2'h1,
        RT_HUB = 2'h2,
        RT_IGNORE = 2'h3
    } pcd_route_t;

    typedef enum logic [1:0] {
        HK_IO_RD = 2'h0,
        HK_IO_WR = 2'h1,
        HK_CFG_RD = 2'h2,
        HK_CFG_WR = 2'h3
    } pcd_hub_kind_t;

    typedef struct packed {
        pcd_hub_kind_t kind;
        logic [DATA_W-1:0] hub_address_lines;
        logic [LANES-1:0] be;
        logic [DATA_W-1:0] wdata;
    } pcd_hub_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RAM = 2'h1,
        ST_DONE = 2'h3,
        ST_HUB = 2'h2
    } pcd_state_t;

    function automatic logic io_match(input logic [IO_ADDR_W-1:0] a,
                                      input logic [IO_ADDR_W-1:0] b);
        return a[IO_ADDR_W-1:2] == b[IO_ADDR_W-1:2];
    endfunction

    function automatic pcd_route_t decode_route(input pcd_ptr_t p);
        pcd_route_t r;
        r = RT_HUB;
        if (p.bus == BUS_ZERO && (p.dev == DEV_HOST || p.dev == DEV_GFX))
        begin
            if (p.func != FUNC_ZERO)
                r = RT_IGNORE;
            else if (p.dev == DEV_HOST)
                r = RT_HOST;
            else
                r = RT_GFX;
        end
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] cfg_hub_addr(input pcd_ptr_t p);
        return {HUB_ADDR_FILL, p.bus, p.dev, p.func, p.regnum, ADDR_LOW_ZERO};
    endfunction

endpackage

// File: logic/pcd_cfg_ram.sv
// byte-lane configuration storage for the two internal functions, registered read
`timescale 1ns/10ps
module pcd_cfg_ram
    import pcd_pkg::*;
#(
    parameter int ADDR_W = 7,
    parameter int DEPTH = 128
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic rd,
    input wire logic we,
    input wire logic [LANES-1:0] be,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);

    logic [DATA_W-1:0] mem [DEPTH];

    // lane i holds the byte at offset i, so lower addresses carry lower bits
    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (we && be[i])
                mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rdata <= RDATA_RESET;
        else if (rd)
            rdata <= mem[addr];
    end

endmodule // pcd_cfg_ram

// File: logic/pcd_config_decoder.sv
// host I/O decoder for the configuration pointer and data window, steering cycles
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
module pcd_config_decoder
    import pcd_pkg::*;
#(
    parameter int RAM_ADDR_W = 7,
    parameter int RAM_DEPTH = 128
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [IO_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [LANES-1:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output pcd_hub_req_t hub_req,
    output logic hub_req_valid,
    input wire logic hub_done,
    input wire logic [DATA_W-1:0] hub_rdata,
    output logic cfg_access_enable
);

    pcd_state_t state;
    pcd_state_t next_state;
    pcd_ptr_t ptr;
    pcd_ptr_t next_ptr;
    pcd_hub_req_t next_hub_req;
    logic [DATA_W-1:0] next_readdata;
    logic [DATA_W-1:0] ram_rdata;

    // request decode
    wire req = avs_read | avs_write;
    wire take = (state == ST_IDLE) && req;
    // only the pointer and the window are claimed; there is no second access method
    wire hit_ptr = io_match(avs_address, IO_PTR_ADDR);
    wire hit_win = io_match(avs_address, IO_WIN_ADDR);
    wire be_dword = avs_byteenable == BE_DWORD;
    wire ptr_dword = hit_ptr && be_dword;
    wire win_cfg = hit_win && ptr.enable;
    pcd_route_t route;
    assign route = decode_route(ptr);
    wire route_int = (route == RT_HOST) || (route == RT_GFX);
    wire route_ign = route == RT_IGNORE;

    wire take_ptr = take && ptr_dword;
    wire take_int = take && win_cfg && route_int;
    wire take_ign = take && win_cfg && route_ign;
    // everything not claimed here leaves as a hub cycle: plain I/O or configuration
    wire take_hub = take && !ptr_dword && !(win_cfg && !(route == RT_HUB));

    // hub request assembly
    wire [DATA_W-1:0] io_hub_addr = {IO_ADDR_FILL, avs_address};
    wire [DATA_W-1:0] cfg_addr = cfg_hub_addr(ptr);
    pcd_hub_kind_t hub_kind;
    pcd_hub_req_t fresh_hub_req;
    assign hub_kind = win_cfg ? (avs_write ? HK_CFG_WR : HK_CFG_RD)
                              : (avs_write ? HK_IO_WR : HK_IO_RD);
    assign fresh_hub_req = pcd_hub_req_t'{kind: hub_kind,
                                          hub_address_lines: win_cfg ? cfg_addr : io_hub_addr,
                                          be: avs_byteenable,
                                          wdata: avs_writedata};
    // the request is frozen while the hub works, so the hub never sees it move
    assign next_hub_req = take_hub ? fresh_hub_req : hub_req;

    // internal storage port; function zero only, so the address is device plus register
    wire gfx_sel = route == RT_GFX;
    wire [RAM_ADDR_W-1:0] ram_addr = RAM_ADDR_W'({gfx_sel, ptr.regnum});
    wire ram_we = take_int && avs_write;
    wire ram_rd = take_int && avs_read;

    pcd_cfg_ram #(
        .ADDR_W(RAM_ADDR_W),
        .DEPTH(RAM_DEPTH)
    ) u_cfg_ram (
        .core_clk(core_clk),
        .rst(rst),
        .addr(ram_addr),
        .rd(ram_rd),
        .we(ram_we),
        .be(avs_byteenable),
        .wdata(avs_writedata),
        .rdata(ram_rdata)
    );

    // pointer update; reserved bits stay zero so a read shows only live fields
    assign next_ptr = (take_ptr && avs_write) ? pcd_ptr_t'(avs_writedata & PTR_WRITE_MASK)
                                              : ptr;

    // sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (take_ptr || take_ign || (take_int && avs_write))
                    next_state = ST_DONE;
                else if (take_int)
                    next_state = ST_RAM;
                else if (take_hub)
                    next_state = ST_HUB;
            end
            ST_RAM:
            begin
                next_state = ST_DONE;
            end
            ST_HUB:
            begin
                if (hub_done)
                    next_state = ST_DONE;
            end
            ST_DONE:
            begin
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // read data source; ignored configuration reads float high like a master abort
    always_comb
    begin
        next_readdata = avs_readdata;
        case (state)
            ST_IDLE:
            begin
                if (take_ptr && avs_read)
                    next_readdata = ptr;
                else if (take_ign && avs_read)
                    next_readdata = ABORT_DATA;
            end
            ST_RAM:
            begin
                next_readdata = ram_rdata;
            end
            ST_HUB:
            begin
                // a hub write leaves the last read data in place
                if (hub_done && avs_read)
                    next_readdata = hub_rdata;
            end
            default:
            begin
                next_readdata = avs_readdata;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ptr <= PTR_RESET;
        else
            ptr <= next_ptr;
    end

    // the enable bit gets its own flop so the status pin needs no decode
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cfg_access_enable <= 1'b0;
        else
            cfg_access_enable <= next_ptr.enable;
    end

    // waitrequest is held high except for the one cycle that completes a transfer,
    // which costs a cycle of latency but keeps it a clean flop output
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= next_state != ST_DONE;
    end

    // read data hold until the next read completes, so a late sample still sees them
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            avs_readdata <= RDATA_RESET;
        else
            avs_readdata <= next_readdata;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hub_req_valid <= 1'b0;
        else
            hub_req_valid <= next_state == ST_HUB;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hub_req <= '0;
        else
            hub_req <= next_hub_req;
    end

endmodule // pcd_config_decoder

// File: verif/pcd_hub_model.sv
// hub-side responder with an answer delay that changes every transfer
`timescale 1ns/10ps
module pcd_hub_model
    import pcd_pkg::*;
#(
    parameter logic [7:0] bridge_low_bus_bound = 8'h01,
    parameter logic [7:0] bridge_high_bus_bound = 8'hFF
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire pcd_hub_req_t hub_req,
    input wire logic hub_req_valid,
    output logic hub_done,
    output logic [DATA_W-1:0] hub_rdata
);
    logic [2:0] cnt;
    logic [2:0] lag;
    wire logic [7:0] fwd_bus = hub_req.hub_address_lines[23:16];
    // a nonzero bus is only claimed inside the bridge window, else it aborts
    wire logic claimed = fwd_bus == 8'h00
        || (fwd_bus >= bridge_low_bus_bound && fwd_bus <= bridge_high_bus_bound);
    wire logic [DATA_W-1:0] ans = claimed ? hub_req.hub_address_lines ^ 32'h5A5A_A5A5
                                          : ABORT_DATA;
    // outside the answer the lines carry the inverse, so a stale sample never matches
    assign hub_rdata = hub_done ? ans : ~ans;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 3'h0;
            lag <= 3'h0;
            hub_done <= 1'b0;
        end
        else
        begin
            hub_done <= 1'b0;
            if (hub_req_valid && !hub_done)
            begin
                cnt <= cnt + 3'h1;
                if (cnt == lag)
                begin
                    hub_done <= 1'b1;
                    cnt <= 3'h0;
                    lag <= lag + 3'h3;
                end
            end
        end
    end
endmodule // pcd_hub_model

// File: verif/pcd_config_decoder_properties.sv
// port-level assertions for the configuration access decoder
`timescale 1ns/10ps
module pcd_config_decoder_properties
    import pcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [IO_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [LANES-1:0] avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire pcd_hub_req_t hub_req,
    input wire logic hub_req_valid,
    input wire logic hub_done,
    input wire logic [DATA_W-1:0] hub_rdata,
    input wire logic cfg_access_enable
);
    pcd_ptr_t sh;
    wire logic req = avs_read | avs_write;
    wire logic ptr = avs_address[15:2] == IO_PTR_ADDR[15:2];
    wire logic win = avs_address[15:2] == IO_WIN_ADDR[15:2];
    wire logic dw = avs_byteenable == BE_DWORD;
    wire logic own = cfg_access_enable && sh.bus == BUS_ZERO && sh.dev < 5'h02;
    wire logic cfg = hub_req.kind[1];
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            sh <= PTR_RESET;
        else if (avs_write && !avs_waitrequest && ptr && dw)
            sh <= avs_writedata & 32'h80FF_FFFC;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_wait_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
    property p_ptr_en;
        avs_write && !avs_waitrequest && ptr && dw |-> cfg_access_enable == avs_writedata[31];
    endproperty
    a_ptr_en: assert property (p_ptr_en) else $error("enable not from pointer");
    property p_io_route;
        $rose(req) && (win && !cfg_access_enable || ptr && !dw) |=> hub_req_valid && !cfg
            && hub_req.hub_address_lines == {16'h0000, avs_address};
    endproperty
    a_io_route: assert property (p_io_route) else $error("plain I/O not forwarded");
    property p_cfg_route;
        $rose(req) && win && cfg_access_enable && !own |=> hub_req_valid && cfg
            && hub_req.kind[0] == avs_write
            && hub_req.hub_address_lines == {8'h00, sh[23:2], 2'h0};
    endproperty
    a_cfg_route: assert property (p_cfg_route) else $error("hub cfg cycle wrong");
    property p_own;
        $rose(req) && win && own |=> !hub_req_valid [*2];
    endproperty
    a_own: assert property (p_own) else $error("internal cycle leaked");
    property p_abort;
        avs_read && !avs_waitrequest && win && own && sh.func != FUNC_ZERO
            |-> avs_readdata == ABORT_DATA;
    endproperty
    a_abort: assert property (p_abort) else $error("ignored read not all ones");
    property p_wdata;
        hub_req_valid && hub_req.kind[0]
            |-> hub_req.wdata == avs_writedata && hub_req.be == avs_byteenable;
    endproperty
    a_wdata: assert property (p_wdata) else $error("hub write data altered");
    property p_done;
        hub_req_valid && hub_done && avs_read
            |=> !avs_waitrequest && !hub_req_valid && avs_readdata == $past(hub_rdata);
    endproperty
    a_done: assert property (p_done) else $error("hub answer not returned");
    c_hub: cover property (hub_req_valid && hub_done && cfg);
    c_own: cover property (avs_read && !avs_waitrequest && win && own);
    c_io: cover property (hub_req_valid && !cfg);
endmodule // pcd_config_decoder_properties
bind pcd_config_decoder pcd_config_decoder_properties pcd_config_decoder_properties_i (
    .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .hub_req, .hub_req_valid, .hub_done, .hub_rdata,
    .cfg_access_enable);

// File: verif/tb.sv
// self-checking bench for the configuration access decoder
`timescale 1ns/10ps
module tb
    import pcd_pkg::*;
();
    logic core_clk, rst, avs_read, avs_write, avs_waitrequest, hub_req_valid, hub_done;
    logic cfg_access_enable;
    logic [15:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, hub_rdata, v, a, q;
    logic [7:0] b;
    pcd_hub_req_t hub_req;
    int bad_count, compares, cyc;
    integer seed;
    pcd_config_decoder pcd_config_decoder_i (.core_clk, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .hub_req, .hub_req_valid, .hub_done, .hub_rdata, .cfg_access_enable);
    pcd_hub_model pcd_hub_model_i (.core_clk, .rst, .hub_req, .hub_req_valid, .hub_done,
        .hub_rdata);
    function automatic logic [31:0] hd(input logic [31:0] x);
        return x ^ 32'h5A5A_A5A5;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one Avalon transfer; the request stands until waitrequest is seen low
    task automatic xfer(input logic w, input logic [15:0] ad, input logic [3:0] be,
        input logic [31:0] d, output logic [31:0] rd);
        avs_address <= ad;
        avs_byteenable <= be;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    initial
    begin
        seed = 32'h56BA;
        {rst, avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = 'h0;
        rst = 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("enable", {31'h0, cfg_access_enable}, 32'h0);
        xfer(0, IO_PTR_ADDR, 4'hF, 0, q);
        chk("ptr_reset", q, 32'h0);
        v = $random(seed);
        xfer(1, IO_PTR_ADDR, 4'hF, v, q);
        xfer(0, IO_PTR_ADDR, 4'hF, 0, q);
        chk("ptr", q, v & 32'h80FF_FFFC);
        $display("pointer test done");
        for (int d = 0; d < 2; d++)
        begin
            v = $random(seed);
            b = $random(seed);
            xfer(1, IO_PTR_ADDR, 4'hF, {16'h8000, d[4:0], 3'h0, b[5:0], 2'h0}, q);
            chk("enable_on", {31'h0, cfg_access_enable}, 32'h1);
            xfer(1, IO_WIN_ADDR, 4'hF, v, q);
            xfer(1, IO_WIN_ADDR, 4'h2, {4{b}}, q);
            xfer(0, IO_WIN_ADDR, 4'hF, 0, q);
            chk("internal", q, {v[31:16], b, v[7:0]});
        end
        xfer(1, IO_PTR_ADDR, 4'hF, 32'h8000_0500, q);
        xfer(0, IO_WIN_ADDR, 4'hF, 0, q);
        chk("ignored", q, 32'hFFFF_FFFF);
        $display("internal test done");
        for (int i = 0; i < 6; i++)
        begin
            v = $random(seed);
            a = (v & 32'h00FF_FFFC) | 32'h8000_0000;
            if (i < 2)
                a[23:11] = i ? 13'h001F : 13'h0002;
            else
                a[16] = 1'b1;
            xfer(1, IO_PTR_ADDR, 4'hF, a, q);
            xfer(0, IO_WIN_ADDR, 4'hF, 0, q);
            chk("hub_cfg", q, hd(a & 32'h00FF_FFFC));
            xfer(1, IO_WIN_ADDR, 4'hF, v, q);
        end
        $display("hub test done");
        xfer(1, IO_PTR_ADDR, 4'hF, 0, q);
        chk("disable", {31'h0, cfg_access_enable}, 32'h0);
        xfer(0, IO_WIN_ADDR, 4'hF, 0, q);
        chk("win_io", q, hd({16'h0, IO_WIN_ADDR}));
        xfer(1, IO_PTR_ADDR, 4'h3, 32'h8000_0000, q);
        xfer(0, IO_PTR_ADDR, 4'hF, 0, q);
        chk("narrow", q, 32'h0);
        xfer(0, IO_PTR_ADDR, 4'h1, 0, q);
        chk("narrow_io", q, hd({16'h0, IO_PTR_ADDR}));
        xfer(0, 16'h0080, 4'hF, 0, q);
        chk("other_io", q, hd(32'h0000_0080));
        $display("pass-through test done");
        report_and_stop();
    end
endmodule // tb
